// ==== hdl/irq_prio_defines.vh ====
// register offsets, field positions and reset values of the interrupt priority block
`ifndef IRQ_PRIO_DEFINES_VH
`define IRQ_PRIO_DEFINES_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CORE_SOURCE_PRIORITY_IDX 3'h0
`define PERIPH_SOURCE_PRIORITY_A_IDX 3'h1
`define PERIPH_SOURCE_PRIORITY_B_IDX 3'h2
`define REQ_STATUS_LO_IDX 3'h3
`define REQ_STATUS_HI_IDX 3'h4
`define ARB_STATUS_IDX 3'h5

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define CORE_SOURCE_PRIORITY_RST 16'h0000
`define PERIPH_SOURCE_PRIORITY_A_RST 16'h0000
`define PERIPH_SOURCE_PRIORITY_B_RST 16'h0000
`define CORE_RESERVED_MASK 16'h0c00
`define FIELD_DISABLED 2'h0

// ----------------------------------------------------------------
// field positions, core register
// ----------------------------------------------------------------
`define CLOCK_LOCK_LEVEL_LSB 14
`define LOW_VOLTAGE_LEVEL_LSB 12
`define DEBUG_RX_FULL_LEVEL_LSB 8
`define DEBUG_TX_EMPTY_LEVEL_LSB 6
`define DEBUG_TRACE_LEVEL_LSB 4
`define DEBUG_BREAKPOINT_LEVEL_LSB 2
`define DEBUG_STEP_LEVEL_LSB 0

// ----------------------------------------------------------------
// field positions, peripheral register a
// ----------------------------------------------------------------
`define PORT_D_LEVEL_LSB 14
`define CAN_WAKE_LEVEL_LSB 12
`define CAN_TRANSMIT_LEVEL_LSB 10
`define CAN_RECEIVE_LEVEL_LSB 8
`define CAN_ERROR_LEVEL_LSB 6
`define FLASH_BUFFERS_EMPTY_LEVEL_LSB 4
`define FLASH_CMD_DONE_LEVEL_LSB 2
`define FLASH_ERROR_LEVEL_LSB 0

// ----------------------------------------------------------------
// field positions, peripheral register b
// ----------------------------------------------------------------
`define SERIAL0_TX_EMPTY_LEVEL_LSB 14
`define SPI1_TX_EMPTY_LEVEL_LSB 12
`define SPI1_RX_FULL_LEVEL_LSB 10
`define SPI0_TX_EMPTY_LEVEL_LSB 8
`define SPI0_RX_FULL_LEVEL_LSB 6
`define PORT_A_LEVEL_LSB 4
`define PORT_B_LEVEL_LSB 2
`define PORT_C_LEVEL_LSB 0

// ----------------------------------------------------------------
// arbitration status fields
// ----------------------------------------------------------------
`define ARB_VALID_BIT 15
`define ARB_RSVD_FLAG_BIT 14

`endif

// ==== hdl/prio_field_decode.v ====
// decode of one 2-bit priority field into enable and level
`timescale 1ns/10ps
`default_nettype none
`include "irq_prio_defines.vh"

module prio_field_decode #(
	parameter CORE = 1
) (
	input wire [1:0] code,
	output wire enable,
	output wire [1:0] level
);

	// ----------------------------------------------------------------
	// mapping
	// ----------------------------------------------------------------
	// core codes are the level itself, peripheral codes sit one above it
	function [1:0] map_level;
		input [1:0] c;
		input core_src;
		begin
			if (core_src) begin
				map_level = c;
			end else begin
				map_level = c - 2'h1;
			end
		end
	endfunction

	assign enable = (code != `FIELD_DISABLED);
	assign level = enable ? map_level(code, CORE != 0) : 2'h0;

endmodule

`default_nettype wire

// ==== hdl/prio_arbiter.v ====
// selects the highest-level active request, lowest index on a tie
`timescale 1ns/10ps
`default_nettype none

module prio_arbiter #(
	parameter N = 23,
	parameter SW = 5
) (
	input wire [N-1:0] req,
	input wire [2*N-1:0] lvl,
	output reg valid,
	output reg [1:0] level,
	output reg [SW-1:0] source
);

	integer i;

	// ----------------------------------------------------------------
	// search
	// ----------------------------------------------------------------
	always @* begin
		valid = 1'b0;
		level = 2'h0;
		source = {SW{1'b0}};
		for (i = 0; i < N; i = i + 1) begin
			if (req[i] && (!valid || lvl[2*i +: 2] > level)) begin
				valid = 1'b1;
				level = lvl[2*i +: 2];
				source = i[SW-1:0];
			end
		end
	end

endmodule

`default_nettype wire

// ==== hdl/irq_priority_level_config.v ====
// interrupt priority configuration registers and request forwarding
//
// Behaviour
// - each source has a 2-bit field; 00 disables it; all fields reset to 00
// - core register codes 01, 10, 11 give levels 1, 2, 3
// - peripheral register codes 01, 10, 11 give levels 0, 1, 2
// - core bits 15:14 set the clock loss or lock change level
// - core bits 13:12 set the low-voltage level, disabled after reset
// - core bits 9:8 debug receive full, bits 7:6 debug transmit empty
// - core bits 5:4 trace buffer, 3:2 breakpoint, 1:0 step counter
// - periph a bits 15:14 port d, 13:12 can wake, 11:10 can transmit
// - periph a bits 9:8 can receive, bits 7:6 can error
// - periph a bits 5:4 flash buffers empty, 3:2 command done, 1:0 error
// - periph b bits 15:14 serial0 tx, 13:12 spi1 tx, 11:10 spi1 rx
// - periph b bits 9:8 spi0 transmit empty, bits 7:6 spi0 receive full
// - periph b bits 5:4 port a, bits 3:2 port b, levels 0 to 2
// - periph b bits 1:0 port c, levels 0 to 2, disabled after reset
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "irq_prio_defines.vh"

module irq_priority_level_config #(
	parameter ADDR_W = 3,
	parameter DATA_W = 16,
	parameter SRC_W = 5
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [ADDR_W-1:0] addr,
	input wire [DATA_W-1:0] wr_data,
	input wire wr_en,
	input wire rd_en,
	output wire [DATA_W-1:0] rd_data,
	input wire [22:0] src_req,
	output wire [22:0] irq_req,
	output wire [3:0] level_req,
	output wire irq_valid,
	output wire [1:0] irq_level,
	output wire [SRC_W-1:0] irq_source
);

	localparam NSRC = 23;
	localparam NCORE = 7;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [15:0] core_source_priority_q;
	reg [15:0] periph_source_priority_a_q;
	reg [15:0] periph_source_priority_b_q;
	reg rsvd_flag_q;
	reg [DATA_W-1:0] rd_data_q;
	reg [DATA_W-1:0] rd_data_d;
	reg [NSRC-1:0] irq_req_q;
	reg [3:0] level_req_q;
	reg [3:0] level_req_d;
	reg irq_valid_q;
	reg [1:0] irq_level_q;
	reg [SRC_W-1:0] irq_source_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire wr_core;
	wire wr_per_a;
	wire wr_per_b;
	wire wr_arb;
	wire rsvd_hit;
	wire rsvd_clr;

	assign wr_core = wr_en && (addr == `CORE_SOURCE_PRIORITY_IDX);
	assign wr_per_a = wr_en && (addr == `PERIPH_SOURCE_PRIORITY_A_IDX);
	assign wr_per_b = wr_en && (addr == `PERIPH_SOURCE_PRIORITY_B_IDX);
	assign wr_arb = wr_en && (addr == `ARB_STATUS_IDX);

	// reserved bits written non-zero are caught for software to inspect
	assign rsvd_hit = wr_core && ((wr_data & `CORE_RESERVED_MASK) != 16'h0000);
	assign rsvd_clr = wr_arb && wr_data[`ARB_RSVD_FLAG_BIT];

	// ----------------------------------------------------------------
	// named fields, core register
	// ----------------------------------------------------------------
	wire [1:0] clock_lock_level;
	wire [1:0] low_voltage_level;
	wire [1:0] debug_rx_full_level;
	wire [1:0] debug_tx_empty_level;
	wire [1:0] debug_trace_level;
	wire [1:0] debug_breakpoint_level;
	wire [1:0] debug_step_level;

	assign clock_lock_level = core_source_priority_q[`CLOCK_LOCK_LEVEL_LSB +: 2];
	assign low_voltage_level = core_source_priority_q[`LOW_VOLTAGE_LEVEL_LSB +: 2];
	assign debug_rx_full_level = core_source_priority_q[`DEBUG_RX_FULL_LEVEL_LSB +: 2];
	assign debug_tx_empty_level = core_source_priority_q[`DEBUG_TX_EMPTY_LEVEL_LSB +: 2];
	assign debug_trace_level = core_source_priority_q[`DEBUG_TRACE_LEVEL_LSB +: 2];
	assign debug_breakpoint_level =
		core_source_priority_q[`DEBUG_BREAKPOINT_LEVEL_LSB +: 2];
	assign debug_step_level = core_source_priority_q[`DEBUG_STEP_LEVEL_LSB +: 2];

	// ----------------------------------------------------------------
	// named fields, peripheral register a
	// ----------------------------------------------------------------
	wire [1:0] port_d_level;
	wire [1:0] can_wake_level;
	wire [1:0] can_transmit_level;
	wire [1:0] can_receive_level;
	wire [1:0] can_error_level;
	wire [1:0] flash_buffers_empty_level;
	wire [1:0] flash_cmd_done_level;
	wire [1:0] flash_error_level;

	assign port_d_level = periph_source_priority_a_q[`PORT_D_LEVEL_LSB +: 2];
	assign can_wake_level = periph_source_priority_a_q[`CAN_WAKE_LEVEL_LSB +: 2];
	assign can_transmit_level = periph_source_priority_a_q[`CAN_TRANSMIT_LEVEL_LSB +: 2];
	assign can_receive_level = periph_source_priority_a_q[`CAN_RECEIVE_LEVEL_LSB +: 2];
	assign can_error_level = periph_source_priority_a_q[`CAN_ERROR_LEVEL_LSB +: 2];
	assign flash_buffers_empty_level =
		periph_source_priority_a_q[`FLASH_BUFFERS_EMPTY_LEVEL_LSB +: 2];
	assign flash_cmd_done_level =
		periph_source_priority_a_q[`FLASH_CMD_DONE_LEVEL_LSB +: 2];
	assign flash_error_level = periph_source_priority_a_q[`FLASH_ERROR_LEVEL_LSB +: 2];

	// ----------------------------------------------------------------
	// named fields, peripheral register b
	// ----------------------------------------------------------------
	wire [1:0] serial0_tx_empty_level;
	wire [1:0] spi1_tx_empty_level;
	wire [1:0] spi1_rx_full_level;
	wire [1:0] spi0_tx_empty_level;
	wire [1:0] spi0_rx_full_level;
	wire [1:0] port_a_level;
	wire [1:0] port_b_level;
	wire [1:0] port_c_level;

	assign serial0_tx_empty_level =
		periph_source_priority_b_q[`SERIAL0_TX_EMPTY_LEVEL_LSB +: 2];
	assign spi1_tx_empty_level = periph_source_priority_b_q[`SPI1_TX_EMPTY_LEVEL_LSB +: 2];
	assign spi1_rx_full_level = periph_source_priority_b_q[`SPI1_RX_FULL_LEVEL_LSB +: 2];
	assign spi0_tx_empty_level = periph_source_priority_b_q[`SPI0_TX_EMPTY_LEVEL_LSB +: 2];
	assign spi0_rx_full_level = periph_source_priority_b_q[`SPI0_RX_FULL_LEVEL_LSB +: 2];
	assign port_a_level = periph_source_priority_b_q[`PORT_A_LEVEL_LSB +: 2];
	assign port_b_level = periph_source_priority_b_q[`PORT_B_LEVEL_LSB +: 2];
	assign port_c_level = periph_source_priority_b_q[`PORT_C_LEVEL_LSB +: 2];

	// ----------------------------------------------------------------
	// source ordering
	// ----------------------------------------------------------------
	// source 0 is the step counter, 22 is serial0 transmit empty
	wire [2*NSRC-1:0] codes;

	assign codes = {
		serial0_tx_empty_level,
		spi1_tx_empty_level,
		spi1_rx_full_level,
		spi0_tx_empty_level,
		spi0_rx_full_level,
		port_a_level,
		port_b_level,
		port_c_level,
		port_d_level,
		can_wake_level,
		can_transmit_level,
		can_receive_level,
		can_error_level,
		flash_buffers_empty_level,
		flash_cmd_done_level,
		flash_error_level,
		clock_lock_level,
		low_voltage_level,
		debug_rx_full_level,
		debug_tx_empty_level,
		debug_trace_level,
		debug_breakpoint_level,
		debug_step_level
	};

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	wire [NSRC-1:0] src_en;
	wire [2*NSRC-1:0] src_lvl;
	wire [NSRC-1:0] gated_req;

	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : dec
			prio_field_decode #(
				.CORE(g < NCORE)
			) u_dec (
				.code(codes[2*g +: 2]),
				.enable(src_en[g]),
				.level(src_lvl[2*g +: 2])
			);
		end
	endgenerate

	// a disabled source is blocked here, whatever its request does
	assign gated_req = src_req & src_en;

	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	wire arb_valid;
	wire [1:0] arb_level;
	wire [SRC_W-1:0] arb_source;

	prio_arbiter #(
		.N(NSRC),
		.SW(SRC_W)
	) u_arb (
		.req(gated_req),
		.lvl(src_lvl),
		.valid(arb_valid),
		.level(arb_level),
		.source(arb_source)
	);

	// one bit per level, set while any enabled request sits at it
	integer k;
	always @* begin
		level_req_d = 4'h0;
		for (k = 0; k < NSRC; k = k + 1) begin
			if (gated_req[k]) begin
				level_req_d[src_lvl[2*k +: 2]] = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			core_source_priority_q <= `CORE_SOURCE_PRIORITY_RST;
			periph_source_priority_a_q <= `PERIPH_SOURCE_PRIORITY_A_RST;
			periph_source_priority_b_q <= `PERIPH_SOURCE_PRIORITY_B_RST;
			rsvd_flag_q <= 1'b0;
		end else if (ce) begin
			if (wr_core) begin
				// reserved bits never store, so they read back as zero
				core_source_priority_q <= wr_data & ~`CORE_RESERVED_MASK;
			end
			if (wr_per_a) begin
				periph_source_priority_a_q <= wr_data;
			end
			if (wr_per_b) begin
				periph_source_priority_b_q <= wr_data;
			end
			// set wins over a clear in the same cycle
			if (rsvd_hit) begin
				rsvd_flag_q <= 1'b1;
			end else if (rsvd_clr) begin
				rsvd_flag_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// request outputs
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_req_q <= {NSRC{1'b0}};
			level_req_q <= 4'h0;
			irq_valid_q <= 1'b0;
			irq_level_q <= 2'h0;
			irq_source_q <= {SRC_W{1'b0}};
		end else if (ce) begin
			irq_req_q <= gated_req;
			level_req_q <= level_req_d;
			irq_valid_q <= arb_valid;
			irq_level_q <= arb_level;
			irq_source_q <= arb_source;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always @* begin
		rd_data_d = {DATA_W{1'b0}};
		case (addr)
			`CORE_SOURCE_PRIORITY_IDX: begin
				rd_data_d = core_source_priority_q;
			end
			`PERIPH_SOURCE_PRIORITY_A_IDX: begin
				rd_data_d = periph_source_priority_a_q;
			end
			`PERIPH_SOURCE_PRIORITY_B_IDX: begin
				rd_data_d = periph_source_priority_b_q;
			end
			`REQ_STATUS_LO_IDX: begin
				rd_data_d = irq_req_q[15:0];
			end
			`REQ_STATUS_HI_IDX: begin
				rd_data_d = {4'h0, level_req_q, 1'b0, irq_req_q[22:16]};
			end
			`ARB_STATUS_IDX: begin
				rd_data_d = {irq_valid_q, rsvd_flag_q, 1'b0, irq_source_q, 6'h00, irq_level_q};
			end
			default: begin
				rd_data_d = {DATA_W{1'b0}};
			end
		endcase
	end

	// data stand only in the cycle after the read strobe
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= {DATA_W{1'b0}};
		end else if (ce) begin
			if (rd_en) begin
				rd_data_q <= rd_data_d;
			end else begin
				rd_data_q <= {DATA_W{1'b0}};
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rd_data = rd_data_q;
	assign irq_req = irq_req_q;
	assign level_req = level_req_q;
	assign irq_valid = irq_valid_q;
	assign irq_level = irq_level_q;
	assign irq_source = irq_source_q;

endmodule

`default_nettype wire

// ==== bench/irq_prio_checker_assertions.sv ====
// assertions on the ports of the interrupt priority block
`timescale 1ns/10ps
`default_nettype none
module irq_prio_checker #(
	parameter ADDR_W = 3,
	parameter DATA_W = 16,
	parameter SRC_W = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic [22:0] src_req,
	input wire logic [22:0] irq_req,
	input wire logic [3:0] level_req,
	input wire logic irq_valid,
	input wire logic [1:0] irq_level,
	input wire logic [SRC_W-1:0] irq_source
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic wrote_q;
	// ----------------------------------------------------------------
	// no write since reset means nothing can be enabled
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrote_q <= 1'b0;
		end else if (ce && wr_en) begin
			wrote_q <= 1'b1;
		end
	end
	a_reset_all_off: assert property (!wrote_q |-> irq_req == 23'h0 && !irq_valid)
		else $error("request seen before any configuration");
	a_core_level_min: assert property (irq_valid && irq_source < 7 |-> irq_level != 2'h0)
		else $error("core source at level 0");
	a_periph_no_top: assert property (irq_valid && irq_source > 6 |-> irq_level != 2'h3)
		else $error("peripheral source at level 3");
	a_reserved_zero: assert property (ce && rd_en && addr == 3'h0 |=> rd_data[11:10] == 2'h0)
		else $error("reserved core bits read nonzero");
	a_rdback_periph_a: assert property (ce && wr_en && addr == 3'h1 ##1 ce && rd_en && addr == 3'h1
		|=> rd_data == $past(wr_data, 2))
		else $error("peripheral register a read back wrong");
	a_winner_top: assert property (irq_valid |-> (level_req >> irq_level) == 4'h1)
		else $error("winner level is not the highest pending");
	a_winner_live: assert property (irq_valid |-> irq_req[irq_source])
		else $error("winner is not an active request");
	a_idle_quiet: assert property (!irq_valid |-> irq_req == 23'h0 && level_req == 4'h0
		&& irq_level == 2'h0 && irq_source == 0)
		else $error("outputs not quiet without a request");
	a_req_follow: assert property (ce |=> (irq_req & ~$past(src_req)) == 23'h0)
		else $error("forwarded request without a source request");
	a_unmapped_zero: assert property (ce && rd_en && addr > 3'h5 |=> rd_data == 16'h0)
		else $error("unmapped index read nonzero");
	c_top_level: cover property (irq_valid && irq_level == 2'h3);
	c_low_level: cover property (irq_valid && irq_level == 2'h0);
	c_core_read: cover property (rd_en && addr == 3'h0);
endmodule
bind irq_priority_level_config irq_prio_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
	.SRC_W(SRC_W)) u_chk (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data),
	.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .src_req(src_req), .irq_req(irq_req),
	.level_req(level_req), .irq_valid(irq_valid), .irq_level(irq_level),
	.irq_source(irq_source));
`default_nettype wire

// ==== bench/core_model.sv ====
// behavioural model of the processor core taking prioritised requests
`timescale 1ns/10ps
`default_nettype none
module core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_valid,
	input wire logic [1:0] irq_level,
	input wire logic [4:0] irq_source,
	output logic [1:0] seen_level,
	output logic [4:0] seen_source,
	output logic [15:0] taken
);
	// takes the presented winner each cycle it is valid
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			seen_level <= 2'h0;
			seen_source <= 5'h00;
			taken <= 16'h0000;
		end else if (irq_valid) begin
			seen_level <= irq_level;
			seen_source <= irq_source;
			taken <= taken + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ==== bench/test_irq_priority_level_config.sv ====
// testbench for the interrupt priority configuration block
`timescale 1ns/10ps
`default_nettype none
module test_irq_priority_level_config;
	typedef struct packed {
		logic [2:0] a;
		logic [15:0] d;
		logic [22:0] s;
		logic v;
		logic [1:0] l;
		logic [4:0] n;
	} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [15:0] wr_data = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [22:0] src_req = 23'h0;
	logic [15:0] rd_data, taken;
	logic [22:0] irq_req;
	logic [3:0] level_req;
	logic irq_valid;
	logic [1:0] irq_level, seen_level;
	logic [4:0] irq_source, seen_source;
	int n_fail = 0;
	int comparisons = 0;
	row_t rows [6] = '{
		'{3'h0, 16'hc000, 23'h000040, 1'b1, 2'h3, 5'h06},
		'{3'h1, 16'h0003, 23'h0000c0, 1'b1, 2'h3, 5'h06},
		'{3'h0, 16'h4000, 23'h0000c0, 1'b1, 2'h2, 5'h07},
		'{3'h2, 16'h0003, 23'h008080, 1'b1, 2'h2, 5'h07},
		'{3'h2, 16'h0001, 23'h008000, 1'b1, 2'h0, 5'h0f},
		'{3'h0, 16'h0000, 23'h000040, 1'b0, 2'h0, 5'h00}};

	always #2.5 clk = ~clk;

	irq_priority_level_config u_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.src_req(src_req), .irq_req(irq_req), .level_req(level_req), .irq_valid(irq_valid),
		.irq_level(irq_level), .irq_source(irq_source));
	core_model u_core (.clk(clk), .rst(rst), .irq_valid(irq_valid), .irq_level(irq_level),
		.irq_source(irq_source), .seen_level(seen_level), .seen_source(seen_source),
		.taken(taken));

	// ----------------------------------------------------------------
	// bus and request tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// write then read back with no gap
	task automatic wrd(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
	endtask
	task automatic rq(input logic [22:0] s);
		@(posedge clk);
		src_req <= s;
		@(posedge clk);
		#1;
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge clk);
		n_fail++;
		$display("test watchdog expired");
		close_out;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int s, c, ra, lsb, lv;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rq(23'h7fffff);
		chk(irq_req, 0);
		chk(irq_valid, 0);
		for (s = 0; s < 3; s++) begin
			rd(s[2:0]);
			chk(rd_data, 16'h0000);
		end
		$display("test reset done");
		foreach (rows[i]) begin
			wrd(rows[i].a, rows[i].d);
			chk(rd_data, rows[i].d);
			rq(rows[i].s);
			chk(irq_valid, rows[i].v);
			chk(irq_level, rows[i].l);
			chk(irq_source, rows[i].n);
		end
		chk(seen_source, 5'h0f);
		wrd(3'h1, 16'h0000);
		wrd(3'h2, 16'h0000);
		$display("test rows done");
		for (s = 0; s < 23; s++) begin
			ra = (s < 7) ? 0 : (s < 15) ? 1 : 2;
			lsb = (s == 5) ? 12 : (s == 6) ? 14 : (s < 7) ? 2 * s : 2 * ((s - 7) % 8);
			for (c = 1; c < 4; c++) begin
				lv = (s < 7) ? c : c - 1;
				wrd(ra[2:0], 16'(c << lsb));
				chk(rd_data, c << lsb);
				rq(23'h1 << s);
				chk(irq_req, 1 << s);
				chk(irq_level, lv);
				chk(irq_source, s);
				chk(level_req, 1 << lv);
			end
			wrd(ra[2:0], 16'h0000);
			rq(23'h1 << s);
			chk(irq_req, 0);
		end
		$display("test field sweep done");
		wrd(3'h0, 16'h0c01);
		chk(rd_data, 16'h0001);
		rd(3'h5);
		chk(rd_data[14], 1'b1);
		wrd(3'h5, 16'h4000);
		chk(rd_data[14], 1'b0);
		wrd(3'h6, 16'hffff);
		chk(rd_data, 16'h0000);
		rd(3'h0);
		chk(rd_data, 16'h0001);
		rq(23'h000001);
		rd(3'h3);
		chk(rd_data, 16'h0001);
		rd(3'h4);
		chk(rd_data, 16'h0200);
		rd(3'h5);
		chk(rd_data, 16'h8001);
		$display("test refusals done");
		@(posedge clk);
		ce <= 1'b0;
		wrd(3'h0, 16'h0003);
		chk(rd_data, 16'h0000);
		chk(irq_level, 2'h1);
		@(posedge clk);
		ce <= 1'b1;
		rd(3'h0);
		chk(rd_data, 16'h0001);
		chk(taken != 16'h0000, 1'b1);
		$display("test clock enable done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rq(23'h7fffff);
		chk(irq_req, 0);
		rd(3'h0);
		chk(rd_data, 16'h0000);
		chk(taken, 16'h0000);
		$display("test second reset done");
		close_out;
	end
endmodule
`default_nettype wire
